/* rtl/bmwd_pkg.sv */
// Package with register map, field layout and carrier types of the memory window decoder
package bmwd_pkg;
    // Printed offsets are byte addresses of 16-bit registers; not all are multiples of
    // four, so each is kept as an index and the bus address is four times the index.
    localparam logic [7:0]  IDX_NP_BASE     = 8'h20;
    localparam logic [7:0]  IDX_NP_LIMIT    = 8'h22;
    localparam logic [7:0]  IDX_PF_BASE     = 8'h24;
    localparam logic [7:0]  IDX_PF_LIMIT    = 8'h26;
    localparam logic [7:0]  IDX_SEC_STATUS  = 8'h1E;
    localparam logic [15:0] RST_BASE        = 16'hFFF0;
    localparam logic [15:0] RST_LIMIT       = 16'h0000;
    localparam int          FIELD_LSB       = 4;
    localparam int          FIELD_W         = 12;
    localparam int          ADDR_CMP_LSB    = 20;
    localparam int          FAST_CAP_BIT    = 5;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } bmwd_access_t;

    typedef struct packed {
        logic forward;
        logic prefetch;
        logic nonprefetch;
    } bmwd_route_t;
endpackage

/* rtl/bmwd_top.sv */
// AXI4-Lite register bank and memory window decode of the bridge function
`timescale 1ns/1ps
module bmwd_top (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [31:0]           s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output      logic                  s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output      logic                  s_axi_wready,
    output      logic [1:0]            s_axi_bresp,
    output      logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [31:0]           s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output      logic                  s_axi_arready,
    output      logic [31:0]           s_axi_rdata,
    output      logic [1:0]            s_axi_rresp,
    output      logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire bmwd_pkg::bmwd_access_t cpu_access,
    output      bmwd_pkg::bmwd_route_t  route
);
    import bmwd_pkg::*;

    logic [FIELD_W-1:0] np_base_q, np_limit_q, pf_base_q, pf_limit_q;
    logic               aw_held_q, w_held_q, bvalid_q, rvalid_q;
    logic [31:0]        awaddr_q, wdata_q, rdata_q;
    logic [3:0]         wstrb_q;
    logic [1:0]         bresp_q, rresp_q;
    bmwd_route_t        route_q;

    function automatic logic [7:0] reg_index(input logic [31:0] a);
        reg_index = a[9:2];
    endfunction

    function automatic logic is_mapped(input logic [31:0] a);
        logic [7:0] i;
        i = reg_index(a);
        is_mapped = (a[31:10] == 22'h0) && (a[1:0] == 2'b00) &&
                    (i == IDX_NP_BASE || i == IDX_NP_LIMIT || i == IDX_PF_BASE ||
                     i == IDX_PF_LIMIT || i == IDX_SEC_STATUS);
    endfunction

    function automatic logic [FIELD_W-1:0] merge(input logic [FIELD_W-1:0] old,
                                                 input logic [31:0] d,
                                                 input logic [3:0] s);
        logic [15:0] o;
        o = {old, 4'h0};
        if (s[0]) o[7:0] = d[7:0];
        if (s[1]) o[15:8] = d[15:8];
        merge = o[15:FIELD_LSB];
    endfunction

    function automatic logic in_window(input logic [31:0] a,
                                       input logic [FIELD_W-1:0] b,
                                       input logic [FIELD_W-1:0] l);
        logic [31:0] lo, hi;
        lo = {b, 20'h00000};
        hi = {l, 20'hFFFFF};
        in_window = (a >= lo) && (a <= hi);
    endfunction

    // Write path: address and data accepted in either order
    wire        aw_have   = aw_held_q | s_axi_awvalid;
    wire        w_have    = w_held_q | s_axi_wvalid;
    wire [31:0] wr_addr   = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data   = w_held_q ? wdata_q : s_axi_wdata;
    wire [3:0]  wr_strb   = w_held_q ? wstrb_q : s_axi_wstrb;
    wire        wr_fire   = aw_have && w_have && !bvalid_q;
    wire [7:0]  wr_idx    = reg_index(wr_addr);
    wire        wr_ok     = is_mapped(wr_addr);

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            awaddr_q  <= 32'h0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
        end else begin
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_q <= 1'b1;
                    awaddr_q  <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_q <= 1'b1;
                    wdata_q  <= s_axi_wdata;
                    wstrb_q  <= s_axi_wstrb;
                end
                if (bvalid_q && s_axi_bready) bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            np_base_q  <= RST_BASE[15:FIELD_LSB];
            np_limit_q <= RST_LIMIT[15:FIELD_LSB];
            pf_base_q  <= RST_BASE[15:FIELD_LSB];
            pf_limit_q <= RST_LIMIT[15:FIELD_LSB];
        end else if (wr_fire && wr_ok) begin
            if (wr_idx == IDX_NP_BASE)  np_base_q  <= merge(np_base_q, wr_data, wr_strb);
            if (wr_idx == IDX_NP_LIMIT) np_limit_q <= merge(np_limit_q, wr_data, wr_strb);
            if (wr_idx == IDX_PF_BASE)  pf_base_q  <= merge(pf_base_q, wr_data, wr_strb);
            if (wr_idx == IDX_PF_LIMIT) pf_limit_q <= merge(pf_limit_q, wr_data, wr_strb);
        end
    end

    // Read path
    wire [7:0]  rd_idx = reg_index(s_axi_araddr);
    wire        rd_ok  = is_mapped(s_axi_araddr);
    wire [15:0] status_word = 16'(1 << FAST_CAP_BIT);
    logic [15:0] rd_word;
    logic [7:0]  rd_idx_q;
    assign rd_word = (rd_idx == IDX_NP_BASE)    ? {np_base_q, 4'h0}  :
                     (rd_idx == IDX_NP_LIMIT)   ? {np_limit_q, 4'h0} :
                     (rd_idx == IDX_PF_BASE)    ? {pf_base_q, 4'h0}  :
                     (rd_idx == IDX_PF_LIMIT)   ? {pf_limit_q, 4'h0} :
                     (rd_idx == IDX_SEC_STATUS) ? status_word : 16'h0000;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_ok ? {16'h0000, rd_word} : 32'h0;
            rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Decode; both hits may be set together when windows overlap, no arbitration
    // window hits
    wire np_hit = cpu_access.valid && in_window(cpu_access.addr, np_base_q, np_limit_q);
    wire pf_hit = cpu_access.valid && in_window(cpu_access.addr, pf_base_q, pf_limit_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_q <= '0;
        end else begin
            route_q.nonprefetch <= np_hit;
            route_q.prefetch    <= pf_hit;
            route_q.forward     <= np_hit | pf_hit;
        end
    end
    assign route = route_q;

    property p_np_route;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> (route.nonprefetch ==
            ($past(cpu_access.valid) && ($past(cpu_access.addr[31:20]) >= $past(np_base_q))
             && ($past(cpu_access.addr[31:20]) <= $past(np_limit_q))));
    endproperty
    a_np_route: assert property (p_np_route) else $error("np route wrong");

    property p_pf_route;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> (route.prefetch ==
            ($past(cpu_access.valid) && ($past(cpu_access.addr[31:20]) >= $past(pf_base_q))
             && ($past(cpu_access.addr[31:20]) <= $past(pf_limit_q))));
    endproperty
    a_pf_route: assert property (p_pf_route) else $error("pf route wrong");

    property p_no_stray;
        @(posedge aclk) disable iff (!aresetn)
        route.forward |-> (route.prefetch || route.nonprefetch);
    endproperty
    a_no_stray: assert property (p_no_stray) else $error("stray forward");

    property p_empty_np;
        @(posedge aclk) disable iff (!aresetn)
        (np_base_q > np_limit_q) |=> !route.nonprefetch;
    endproperty
    a_empty_np: assert property (p_empty_np) else $error("empty np window hit");

    property p_low_zero;
        @(posedge aclk) disable iff (!aresetn)
        (rvalid_q && rd_idx_q != IDX_SEC_STATUS) |-> (s_axi_rdata[3:0] == 4'h0);
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("low bits not zero");

    property p_cap_one;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && rd_ok && rd_idx == IDX_SEC_STATUS)
            |=> (s_axi_rvalid && s_axi_rdata[FAST_CAP_BIT]);
    endproperty
    a_cap_one: assert property (p_cap_one) else $error("capability bit not one");

    property p_write_lands;
        @(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_ok && wr_idx == IDX_NP_BASE && wr_strb == 4'hF)
            |=> (np_base_q == $past(wr_data[15:4]));
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("base write lost");

    property p_limit_top;
        @(posedge aclk) disable iff (!aresetn)
        (cpu_access.valid && cpu_access.addr[31:20] == np_limit_q &&
         cpu_access.addr[31:20] >= np_base_q) |=> route.nonprefetch;
    endproperty
    a_limit_top: assert property (p_limit_top) else $error("limit block missed");

    property p_pf_limit_top;
        @(posedge aclk) disable iff (!aresetn)
        (cpu_access.valid && cpu_access.addr[31:20] == pf_limit_q &&
         cpu_access.addr[31:20] >= pf_base_q) |=> route.prefetch;
    endproperty
    a_pf_limit_top: assert property (p_pf_limit_top) else $error("pf limit missed");

    property p_base_bottom;
        @(posedge aclk) disable iff (!aresetn)
        (cpu_access.valid && cpu_access.addr[31:20] == np_base_q &&
         np_base_q <= np_limit_q) |=> route.nonprefetch;
    endproperty
    a_base_bottom: assert property (p_base_bottom) else $error("base block missed");

    property p_pf_base_bottom;
        @(posedge aclk) disable iff (!aresetn)
        (cpu_access.valid && cpu_access.addr[31:20] == pf_base_q &&
         pf_base_q <= pf_limit_q) |=> route.prefetch;
    endproperty
    a_pf_base_bottom: assert property (p_pf_base_bottom) else $error("pf base missed");

    property p_empty_pf;
        @(posedge aclk) disable iff (!aresetn)
        (pf_base_q > pf_limit_q) |=> !route.prefetch;
    endproperty
    a_empty_pf: assert property (p_empty_pf) else $error("empty pf window hit");

    property p_idle_silent;
        @(posedge aclk) disable iff (!aresetn)
        !cpu_access.valid |=> !route.forward;
    endproperty
    a_idle_silent: assert property (p_idle_silent) else $error("idle forwarded");

    property p_hit_forwards;
        @(posedge aclk) disable iff (!aresetn)
        (route.prefetch || route.nonprefetch) |-> route.forward;
    endproperty
    a_hit_forwards: assert property (p_hit_forwards) else $error("hit not forwarded");

    property p_lane_lands;
        @(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_ok && wr_idx == IDX_NP_LIMIT && wr_strb[0])
            |=> (np_limit_q[3:0] == $past(wr_data[7:4]));
    endproperty
    a_lane_lands: assert property (p_lane_lands) else $error("limit lane lost");

    always_ff @(posedge aclk) begin
        if (!aresetn) rd_idx_q <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready) rd_idx_q <= rd_idx;
    end

endmodule // bmwd_top

/* sim/bmwd_far_model.sv */
// Processor side model that presents memory accesses to the window decoder
`timescale 1ns/1ps
module bmwd_far_model (
    input  wire logic                   aclk,
    input  wire bmwd_pkg::bmwd_access_t req,
    output      bmwd_pkg::bmwd_access_t cpu_access
);
    import bmwd_pkg::*;
    initial cpu_access = '0;
    // Idle address lines toggle so a stale address never looks valid
    always @(posedge aclk) begin
        if (req.valid)
            cpu_access <= req;
        else
            cpu_access <= '{valid: 1'b0, addr: ~cpu_access.addr};
    end
endmodule // bmwd_far_model

/* sim/tb.sv */
// Self-checking bench of the memory window decoder
`timescale 1ns/1ps
module tb;
    import bmwd_pkg::*;
    logic         aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic         arvalid, arready, rvalid, rready;
    logic [31:0]  awaddr, wdata, araddr, rdata;
    logic [1:0]   bresp, rresp;
    logic [3:0]   wstrb;
    logic [11:0]  f [4];
    bmwd_access_t req, cpu_access;
    bmwd_route_t  route;
    int           errors, compares;

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    bmwd_far_model i_far (.aclk(aclk), .req(req), .cpu_access(cpu_access));
    bmwd_top i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_access(cpu_access),
        .route(route));

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("unexpected at %0t: saw %h, want %h", $time, s, e);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d, compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic tmo();
        errors++;
        $display("unexpected at %0t: bus wait ran out", $time);
        end_of_test();
    endtask

    function automatic logic [31:0] ra(input int i);
        return 32'({IDX_NP_BASE, 2'b00}) + 32'(8 * i);
    endfunction

    function automatic bmwd_route_t rt(input logic [31:0] a);
        rt.nonprefetch = a >= {f[0], 20'h00000} && a <= {f[1], 20'hFFFFF};
        rt.prefetch    = a >= {f[2], 20'h00000} && a <= {f[3], 20'hFFFFF};
        rt.forward     = rt.nonprefetch | rt.prefetch;
    endfunction

    // Handshakes are sampled at the falling edge, acted on at the next rising edge
    task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tr;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            ta = awvalid && awready; tw = wvalid && wready; tr = bvalid && bready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) begin
                bready <= 1'b0;
                chk(32'(bresp), 32'(er));
                // One idle edge so the next call never reassigns bready in this step
                @(posedge aclk);
                return;
            end
        end
        tmo();
    endtask

    task automatic axr(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, tr;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            ta = arvalid && arready; tr = rvalid && rready;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                chk(rdata, e);
                chk(32'(rresp), 32'(er));
                @(posedge aclk);
                return;
            end
        end
        tmo();
    endtask

    // Route lags the request by the model register plus the decoder register
    task automatic probe(input logic v, input logic [31:0] a, input logic fo);
        bmwd_route_t e;
        req <= '{valid: v, addr: a};
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        e = v ? rt(a) : '0;
        if (fo) chk(32'(route.forward), 32'(e.forward));
        else chk(32'(route), 32'(e));
        @(posedge aclk);
    endtask

    task automatic prog();
        for (int i = 0; i < 4; i++) axw(ra(i), {16'hFFFF, f[i], 4'hF}, RESP_OKAY);
        for (int i = 0; i < 4; i++) axr(ra(i), {16'h0, f[i], 4'h0}, RESP_OKAY);
    endtask

    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; awaddr = '0; wdata = '0; araddr = '0; req = '0;
        wstrb = 4'hF;
        errors = 0; compares = 0;
        void'($urandom(16));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        f = '{12'hFFF, 12'h000, 12'hFFF, 12'h000};
        for (int i = 0; i < 4; i++) axr(ra(i), {16'h0, f[i], 4'h0}, RESP_OKAY);
        axw(32'({IDX_SEC_STATUS, 2'b00}), 32'h0, RESP_OKAY);
        axr(32'({IDX_SEC_STATUS, 2'b00}), 32'(1) << FAST_CAP_BIT, RESP_OKAY);
        probe(1'b1, 32'hFFF00000, 1'b0);
        for (int i = 0; i < 6; i++) probe(1'b1, $urandom, 1'b0);
        axw(32'h00000400, 32'hFFFF, RESP_SLVERR);
        axr(32'h00000400, 32'h0, RESP_SLVERR);
        for (int k = 0; k < 6; k++) begin
            f[0] = {2'b00, 10'($urandom)};
            f[1] = f[0] + 12'($urandom_range(0, 3));
            f[2] = {2'b10, 10'($urandom)};
            f[3] = f[2] + 12'($urandom_range(0, 3));
            prog();
            for (int w = 0; w < 4; w += 2) begin
                probe(1'b1, {f[w], 20'h00000}, 1'b0);
                probe(1'b1, {f[w], 20'h00000} - 32'h1, 1'b0);
                probe(1'b1, {f[w + 1], 20'hFFFFF}, 1'b0);
                probe(1'b1, {f[w + 1], 20'hFFFFF} + 32'h1, 1'b0);
            end
            probe(1'b1, {f[0], 20'($urandom)}, 1'b0);
            probe(1'b1, {f[2], 20'($urandom)}, 1'b0);
            probe(1'b0, {f[0], 20'h00000}, 1'b0);
            probe(1'b1, $urandom, 1'b0);
        end
        // Mid-run reset must bring the windows back to empty
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        f = '{12'hFFF, 12'h000, 12'hFFF, 12'h000};
        for (int i = 0; i < 4; i++) axr(ra(i), {16'h0, f[i], 4'h0}, RESP_OKAY);
        probe(1'b1, {f[1], 20'h00000}, 1'b0);
        // Overlapped windows: both hits are set, only the forward decision is checked
        f = '{12'h100, 12'h200, 12'h180, 12'h280};
        prog();
        probe(1'b1, 32'h1A012345, 1'b1);
        f = '{12'h300, 12'h2FF, 12'h000, 12'h000};
        prog();
        probe(1'b1, 32'h30000000, 1'b0);
        // Only byte lane 1 written: field bits 11:4 change, bits 3:0 keep
        wstrb <= 4'h2;
        axw(ra(3), 32'h0000AB00, RESP_OKAY);
        wstrb <= 4'hF;
        f[3] = {8'hAB, f[3][3:0]};
        axr(ra(3), {16'h0, f[3], 4'h0}, RESP_OKAY);
        probe(1'b1, 32'h30000000, 1'b0);
        end_of_test();
    end
endmodule // tb
